// ==== inc/rx_word_aligner_cfg.svh ====
// Constants for the receive word aligner: offsets, fields, resets, limits
`ifndef RX_WORD_ALIGNER_CFG_SVH
`define RX_WORD_ALIGNER_CFG_SVH

`define RWA_OFF_CTRL 12'h000
`define RWA_OFF_THRESH 12'h004
`define RWA_OFF_STATUS 12'h008
`define RWA_OFF_MASK 12'h00c
`define RWA_OFF_LIVE 12'h010

`define RWA_CTRL_MODE_BIT 0
`define RWA_CTRL_WIDTH_LSB 1
`define RWA_CTRL_WIDTH_MSB 2
`define RWA_CTRL_RESET 32'h0000_0000
`define RWA_THRESH_RESET 10'h080

`define RWA_ST_RLV_BIT 0
`define RWA_ST_DISP_BIT 1
`define RWA_ST_SLIP_BIT 2
`define RWA_ST_BITS 3

`define RWA_MAX_RUN_8 10'd128
`define RWA_MAX_RUN_10 10'd160
`define RWA_MAX_RUN_16 10'd512
`define RWA_MAX_RUN_20 10'd640
`define RWA_RLV_MIN_CYCLES 2'd2
`define RWA_DATA_W 20
`define RWA_CNT_W 10
`define RWA_SLIP_W 5

`endif

// ==== inc/rx_word_aligner_pkg.sv ====
// Types for the receive word aligner
package rx_word_aligner_pkg;
   typedef enum logic [1:0] {
      width_8,
      width_10,
      width_16,
      width_20
   } width_e;

   typedef enum logic {
      mode_pattern,
      mode_bitslip
   } align_mode_e;

   typedef struct packed {
      logic [19:0] data;
      logic disp_err;
      logic running_disp;
   } rx_word_s;
endpackage

// ==== src/rx_word_aligner.sv ====
// Receive word aligner with run-length check, disparity pass-through and bit slip
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/10ps
`include "rx_word_aligner_cfg.svh"

module rx_word_aligner (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic hsel_i,
   input wire logic hready_i,
   input wire logic [31:0] hwdata_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic [19:0] rx_parallel_i,
   input wire logic rx_disp_err_i,
   input wire logic rx_running_disp_i,
   input wire logic rx_bitslip_i,
   output rx_word_aligner_pkg::rx_word_s rx_word_o,
   output logic rx_rlv_o,
   output logic irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   logic [31:0] ctrl, next_ctrl;
   logic [9:0] thresh, next_thresh;
   logic [2:0] status, next_status;
   logic [2:0] mask, next_mask;
   logic wr_pend, next_wr_pend;
   logic [11:0] wr_addr, next_wr_addr;
   logic [31:0] next_hrdata;
   logic [2:0] events;
   logic addr_ok;
   logic [11:0] a_off;
   logic [9:0] run_max;
   logic [31:0] live;

   rx_word_aligner_pkg::width_e width;
   rx_word_aligner_pkg::align_mode_e mode;
   logic [4:0] width_bits;
   logic slip_allowed;

   assign width = rx_word_aligner_pkg::width_e'(ctrl[`RWA_CTRL_WIDTH_MSB:`RWA_CTRL_WIDTH_LSB]);
   assign mode = rx_word_aligner_pkg::align_mode_e'(ctrl[`RWA_CTRL_MODE_BIT]);
   assign addr_ok = hsel_i && hready_i && htrans_i[1];
   assign a_off = haddr_i[11:0];
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

   always_comb begin
      unique case (width)
         rx_word_aligner_pkg::width_8: begin
            width_bits = 5'd8;
            run_max = `RWA_MAX_RUN_8;
         end
         rx_word_aligner_pkg::width_10: begin
            width_bits = 5'd10;
            run_max = `RWA_MAX_RUN_10;
         end
         rx_word_aligner_pkg::width_16: begin
            width_bits = 5'd16;
            run_max = `RWA_MAX_RUN_16;
         end
         rx_word_aligner_pkg::width_20: begin
            width_bits = 5'd20;
            run_max = `RWA_MAX_RUN_20;
         end
      endcase
   end

   // Slip works only in bit-slip mode and at the two supported widths
   assign slip_allowed = (mode == rx_word_aligner_pkg::mode_bitslip) &&
                         (width == rx_word_aligner_pkg::width_10 ||
                          width == rx_word_aligner_pkg::width_16);

   always_comb begin
      next_ctrl = ctrl;
      next_thresh = thresh;
      next_mask = mask;
      next_status = status;
      next_wr_pend = addr_ok && hwrite_i;
      next_wr_addr = addr_ok ? a_off : wr_addr;
      next_hrdata = hrdata_o;
      if (wr_pend) begin
         unique case (wr_addr)
            `RWA_OFF_CTRL: next_ctrl = {29'h0, hwdata_i[2:0]};
            `RWA_OFF_THRESH: begin
               // Clamp keeps the threshold inside what the width can count
               if (hwdata_i[9:0] > run_max) begin
                  next_thresh = run_max;
               end else begin
                  next_thresh = hwdata_i[9:0];
               end
            end
            `RWA_OFF_STATUS: next_status = status & ~hwdata_i[2:0];
            `RWA_OFF_MASK: next_mask = hwdata_i[2:0];
            default: ;
         endcase
      end
      // A narrower width must not keep a threshold it cannot reach
      if (next_thresh > run_max) begin
         next_thresh = run_max;
      end
      // Set wins over a clear in the same cycle
      next_status = next_status | events;
      if (addr_ok && !hwrite_i) begin
         unique case (a_off)
            `RWA_OFF_CTRL: next_hrdata = ctrl;
            `RWA_OFF_THRESH: next_hrdata = {22'h0, thresh};
            `RWA_OFF_STATUS: next_hrdata = {29'h0, status};
            `RWA_OFF_MASK: next_hrdata = {29'h0, mask};
            `RWA_OFF_LIVE: next_hrdata = live;
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         ctrl <= `RWA_CTRL_RESET;
         thresh <= `RWA_THRESH_RESET;
         status <= 3'h0;
         mask <= 3'h0;
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
         hrdata_o <= 32'h0000_0000;
      end else begin
         ctrl <= next_ctrl;
         thresh <= next_thresh;
         status <= next_status;
         mask <= next_mask;
         wr_pend <= next_wr_pend;
         wr_addr <= next_wr_addr;
         hrdata_o <= next_hrdata;
      end
   end

   assign irq_o = |(status & mask);

   ////////////////////////////////////////////////////////////////////////////
   // Run-length monitor over the incoming bit stream, earliest bit at bit 0
   logic [9:0] run_cnt, next_run_cnt;
   logic last_bit, next_last_bit;
   logic [1:0] rlv_hold, next_rlv_hold;
   logic rlv_hit;

   always_comb begin
      next_run_cnt = run_cnt;
      next_last_bit = last_bit;
      rlv_hit = 1'b0;
      for (int i = 0; i < 20; i++) begin
         if (i < int'(width_bits)) begin
            if (rx_parallel_i[i] != next_last_bit) begin
               next_run_cnt = 10'd1;
            end else if (next_run_cnt != 10'h3ff) begin
               next_run_cnt = next_run_cnt + 10'd1;
            end
            next_last_bit = rx_parallel_i[i];
            if (next_run_cnt > thresh) begin
               rlv_hit = 1'b1;
            end
         end
      end
      if (rlv_hit) begin
         next_rlv_hold = `RWA_RLV_MIN_CYCLES;
      end else if (rlv_hold != 2'd0) begin
         next_rlv_hold = rlv_hold - 2'd1;
      end else begin
         next_rlv_hold = 2'd0;
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         run_cnt <= 10'd0;
         last_bit <= 1'b0;
         rlv_hold <= 2'd0;
      end else begin
         run_cnt <= next_run_cnt;
         last_bit <= next_last_bit;
         rlv_hold <= next_rlv_hold;
      end
   end

   assign rx_rlv_o = (rlv_hold != 2'd0);

   ////////////////////////////////////////////////////////////////////////////
   // Bit slip: two words kept so any offset can be cut out
   logic [19:0] prev_word, next_prev_word;
   logic [4:0] slip_off, next_slip_off;
   logic slip_q, next_slip_q;
   logic slip_rise;
   logic [39:0] pair;
   logic [39:0] shifted;
   logic [19:0] word_mask;
   logic prev_disp_err, next_prev_disp_err;
   logic prev_running_disp, next_prev_running_disp;
   rx_word_aligner_pkg::rx_word_s next_word;

   assign slip_rise = rx_bitslip_i && !slip_q;
   assign word_mask = ~(20'hfffff << width_bits);

   // Previous word in the low bits, current word right above it.
   // A later boundary needs bits of the next word, so data and flags
   // leave two edges after they arrive instead of one.
   assign pair = ({20'h00000, rx_parallel_i & word_mask} << width_bits) |
                 {20'h00000, prev_word & word_mask};

   always_comb begin
      next_prev_word = rx_parallel_i;
      next_prev_disp_err = rx_disp_err_i;
      next_prev_running_disp = rx_running_disp_i;
      next_slip_q = rx_bitslip_i;
      next_slip_off = slip_off;
      if (!slip_allowed) begin
         next_slip_off = 5'd0;
      end else if (slip_rise) begin
         // One step per rising edge; wraps after a full word of slips
         if (slip_off + 5'd1 >= width_bits) begin
            next_slip_off = 5'd0;
         end else begin
            next_slip_off = slip_off + 5'd1;
         end
      end
      // Dropping earliest bits: the window starts slip_off bits later
      shifted = pair >> slip_off;
      next_word.data = shifted[19:0] & word_mask;
      // Flags wait one word too, so they stay beside their data
      next_word.disp_err = prev_disp_err;
      next_word.running_disp = prev_running_disp;
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         prev_word <= 20'h00000;
         prev_disp_err <= 1'b0;
         prev_running_disp <= 1'b0;
         slip_off <= 5'd0;
         slip_q <= 1'b0;
         rx_word_o <= '0;
      end else begin
         prev_word <= next_prev_word;
         prev_disp_err <= next_prev_disp_err;
         prev_running_disp <= next_prev_running_disp;
         slip_off <= next_slip_off;
         slip_q <= next_slip_q;
         rx_word_o <= next_word;
      end
   end

   assign events = {slip_allowed && slip_rise, rx_disp_err_i, rlv_hit};
   assign live = {16'h0, 3'h0, slip_off, 1'b0, rx_running_disp_i, rx_rlv_o, mode, 4'h0};

endmodule

// ==== tb/core_model.sv ====
// Core-side model issuing slip requests
`timescale 1ns/10ps
module core_model (
   input wire logic mclk_i,
   input wire logic go_i,
   output logic rx_bitslip_o,
   output logic busy_o
);
   int hold = 0;
   initial rx_bitslip_o = 1'b0;
   assign busy_o = hold != 0;
   // Exactly the two-cycle minimum high, then at least three cycles low before the next request
   always @(posedge mclk_i) begin
      if (hold == 0 && go_i) begin
         rx_bitslip_o <= 1'b1;
         hold <= 4;
      end else if (hold != 0) begin
         hold <= hold - 1;
         if (hold == 3) rx_bitslip_o <= 1'b0;
      end
   end
endmodule

// ==== tb/rx_aligner_props.sv ====
// Port-level checks for the receive word aligner
`timescale 1ns/10ps
module rx_aligner_props (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hsel_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic rx_disp_err_i,
   input wire logic rx_running_disp_i,
   input wire logic rx_bitslip_i,
   input wire rx_word_aligner_pkg::rx_word_s rx_word_o,
   input wire logic rx_rlv_o,
   input wire logic irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_resp_okay: assert property (!hresp_o) else $error("bad response");
   a_no_wait: assert property (hreadyout_o) else $error("wait state");
   a_rlv_two_cycles: assert property ($rose(rx_rlv_o) |=> rx_rlv_o)
      else $error("short violation flag");
   a_disp_err_step: assert property (!$past(reset_i) && !$past(reset_i, 2) |->
      rx_word_o.disp_err == $past(rx_disp_err_i, 2)) else $error("disp err skew");
   a_run_disp_step: assert property (!$past(reset_i) && !$past(reset_i, 2) |->
      rx_word_o.running_disp == $past(rx_running_disp_i, 2)) else $error("disp skew");
   a_word_cleared: assert property ($fell(reset_i) |-> rx_word_o == '0)
      else $error("word not cleared");
   a_flags_cleared: assert property ($fell(reset_i) |-> !rx_rlv_o && !irq_o)
      else $error("flags not cleared");
   a_rdata_holds: assert property (!(hsel_i && hready_i && htrans_i[1] && !hwrite_i)
      |=> $stable(hrdata_o)) else $error("read data moved");
   c_rlv: cover property ($rose(rx_rlv_o));
   c_irq: cover property ($rose(irq_o));
   c_slip: cover property ($rose(rx_bitslip_i));
endmodule
bind rx_word_aligner rx_aligner_props chk (.*);

// ==== tb/tb_top.sv ====
// Self-checking bench for the receive word aligner
`timescale 1ns/10ps
module tb_top;
   logic mclk_i = 0, reset_i = 1, hwrite_i = 0, hsel_i = 1, go = 0, busy;
   logic rx_disp_err_i = 0, rx_running_disp_i = 0, rx_bitslip_i, hready_i;
   logic [1:0] htrans_i = 0;
   logic [2:0] hsize_i = 3'h2;
   logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, r, pat;
   logic [19:0] rx_parallel_i = 20'h55555, q[$], e;
   logic [15:0] lfsr = 16'h5e8b;
   logic hreadyout_o, hresp_o, rx_rlv_o, irq_o;
   rx_word_aligner_pkg::rx_word_s rx_word_o;
   int errors = 0, cmp_count = 0, i, k;
   int lim[4] = '{128, 160, 512, 640}, ra[4] = '{0, 4, 12, 32}, rv[4] = '{0, 128, 0, 0};
   assign hready_i = hreadyout_o;
   always #12.5 mclk_i = ~mclk_i;
   rx_word_aligner uut (.*);
   core_model core (.mclk_i, .go_i(go), .rx_bitslip_o(rx_bitslip_i), .busy_o(busy));
   ////////////////////////////////////////////////////////////
   task chk(input string n, input logic [31:0] s, e);
      cmp_count++;
      if (s !== e) begin
         errors++;
         $display("[ERR] %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] o);
      haddr_i <= a;
      hwrite_i <= w;
      htrans_i <= 2'h2;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hwdata_i <= d;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      o = hrdata_o;
   endtask
   function logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function logic [31:0] rot(input int w, n);
      return ((pat >> n) | (pat << (w - n))) & ((1 << w) - 1);
   endfunction
   task slip(input int w, n);
      go <= 1'b1;
      @(posedge mclk_i);
      go <= 1'b0;
      do @(posedge mclk_i); while (busy);
      repeat (2) @(posedge mclk_i);
      chk("data", rx_word_o.data & ((1 << w) - 1), rot(w, n));
      bus(0, 32'h10, 0, r);
      chk("offset", r[12:8], n);
   endtask
   task tally_and_finish;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      tally_and_finish;
   end
   initial begin
      repeat (10) @(posedge mclk_i);
      reset_i <= 1'b0;
      @(posedge mclk_i);
      for (i = 0; i < 4; i++) begin
         bus(0, ra[i], 0, r);
         chk("reset", r, rv[i]);
      end
      for (i = 0; i < 40; i++) begin
         lfsr = lfsr_step(lfsr);
         rx_parallel_i <= {4'h0, lfsr};
         rx_disp_err_i <= lfsr[3];
         rx_running_disp_i <= lfsr[9];
         q.push_back({2'h0, lfsr[9], lfsr[3], lfsr});
         @(posedge mclk_i);
         if (i > 1) begin
            e = q.pop_front();
            chk("word", rx_word_o.data[7:0], e[7:0]);
            chk("disp", {rx_word_o.disp_err, rx_word_o.running_disp}, {e[16], e[17]});
         end
      end
      rx_parallel_i <= 20'h55555;
      rx_disp_err_i <= 1'b0;
      for (i = 0; i < 4; i++) begin
         bus(1, 32'h0, i << 1, r);
         bus(1, 32'h4, 32'h3ff, r);
         bus(0, 32'h4, 0, r);
         chk("thresh", r[9:0], lim[i]);
      end
      bus(1, 32'h0, 0, r);
      bus(1, 32'h4, 4, r);
      bus(1, 32'h8, 7, r);
      repeat (8) @(posedge mclk_i);
      chk("rlv", rx_rlv_o, 0);
      rx_parallel_i <= 20'h0;
      repeat (2) @(posedge mclk_i);
      chk("rlv high", rx_rlv_o, 1);
      rx_parallel_i <= 20'h55555;
      repeat (6) @(posedge mclk_i);
      chk("irq masked", irq_o, 0);
      bus(1, 32'hc, 1, r);
      @(posedge mclk_i);
      chk("irq", irq_o, 1);
      bus(1, 32'h8, 7, r);
      @(posedge mclk_i);
      chk("irq clear", irq_o, 0);
      pat = 32'h2d1;
      rx_parallel_i <= 20'h002d1;
      bus(1, 32'h0, 3, r);
      for (k = 1; k <= 10; k++) slip(10, k % 10);
      pat = 32'h9b4d;
      rx_parallel_i <= 20'h09b4d;
      bus(1, 32'h0, 5, r);
      slip(16, 1);
      bus(1, 32'h0, 1, r);
      slip(8, 0);
      bus(1, 32'h0, 2, r);
      slip(10, 0);
      tally_and_finish;
   end
endmodule
